// File: dtr_cpu_model.sv
// processor bus and mode model feeding the debug trigger monitor
`timescale 1ns/1ps
module dtr_cpu_model (
  input  wire        aclk,
  output reg         mon_valid,
  output reg  [17:0] mon_addr,
  output reg  [15:0] mon_data,
  output reg         mon_read,
  output reg         mon_word,
  output reg         tag_exec,
  output reg         halt_debug_enable,
  output reg         halt_debug_active,
  output reg         halt_debug_hw_access,
  output reg         chip_secure
);
  initial begin
    {mon_valid, mon_read, mon_word, tag_exec} = 4'h0;
    {halt_debug_enable, halt_debug_active, halt_debug_hw_access, chip_secure} = 4'h0;
    mon_addr = 18'h00000;
    mon_data = 16'h0000;
  end
  // idle payload is inverted so a stale address never looks like a hit
  task cycle(input logic [17:0] a);
    @(posedge aclk);
    mon_valid <= 1'b1;
    mon_addr <= a;
    mon_data <= 16'h5A5A;
    mon_read <= 1'b1;
    mon_word <= 1'b1;
    @(posedge aclk);
    mon_valid <= 1'b0;
    mon_addr <= ~a;
    mon_data <= 16'hA5A5;
  endtask
  task mode(input logic en, act, hw, sec);
    @(posedge aclk);
    halt_debug_enable <= en;
    halt_debug_active <= act & en;
    halt_debug_hw_access <= hw;
    chip_secure <= sec;
  endtask
endmodule

// File: dtr_debug_trigger.v
// debug trigger unit: register front end, comparators, sequencer and trace store
`timescale 1ns/1ps
// What this block does
// (RULE_01) no matching, breakpoints, tagging or trace during halt-debug access or activity; breakpoints are held off during activity only, not during access
// (RULE_02) entering active halt-debug mode leaves an armed session armed
// (RULE_03) secured chip blocks tracing; matches, breakpoints and tagging still work
// (RULE_04) breakpoints go to software interrupt trap unless halt-debug mode enabled
// (RULE_05) while armed only arm, trigger and bank select bits accept writes; the interrupt status and mask registers also accept writes while armed
// (RULE_06) control one bits 7, 1, 0 writable anytime; all bits readable anytime
// (RULE_07) immediate trigger writable anytime, always reads zero
// (RULE_08) bits 4 and 3 update only if session unarmed at write time
// (RULE_09) write clearing arm leaves bits 4:3; software needs a second write
// (RULE_10) one comparator bank visible in eight-byte window, chosen by bank select
// (RULE_11) window first byte is selected comparator control; A adds NO_DATA_BUS_COMPARE, C lacks size
// (RULE_12) trace full flag mirrored at bit 7 of status and count registers
// (RULE_13) works in every chip mode and uses no external pins
// (RULE_14) bank select 0..2 maps A..C and its state control; 3 maps match flags
// (RULE_15) setting arm puts sequencer into its first state
// (RULE_16) final state breakpoint at once without trace, after trace completes otherwise
// (RULE_17) address from three bytes, 18 bits; trace word read as high and low bytes
`include "dtr_regs.vh"

module dtr_debug_trigger #( // RULE_13
  parameter ADDR_W  = 8,
  parameter DEPTH   = 8,
  parameter PTR_W   = 3
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire              mon_valid,
  input  wire [17:0]       mon_addr,
  input  wire [15:0]       mon_data,
  input  wire              mon_read,
  input  wire              mon_word,
  input  wire              tag_exec,
  input  wire              halt_debug_enable,
  input  wire              halt_debug_active,
  input  wire              halt_debug_hw_access,
  input  wire              chip_secure,
  output reg               brk_halt_q,
  output reg               brk_swi_q,
  output reg               irq_q
);

  localparam [4:0] ST_IDLE  = 5'b00001;
  localparam [4:0] ST_S1    = 5'b00010;
  localparam [4:0] ST_S2    = 5'b00100;
  localparam [4:0] ST_S3    = 5'b01000;
  localparam [4:0] ST_FINAL = 5'b10000;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg               arm_q;
  reg               hms_q;
  reg               bre_q;
  reg  [1:0]        bank_q;
  reg  [7:0]        tctl_q;
  reg  [7:0]        ctl2_q;
  reg  [7:0]        cctl_q [0:2];
  reg  [17:0]       caddr_q [0:2];
  reg  [3:0]        scr_q [0:2];
  reg  [15:0]       cdata_q;
  reg  [15:0]       cmask_q;
  reg  [2:0]        mflag_q;
  reg  [4:0]        state_q;
  reg               tracing_q;
  reg  [15:0]       tbuf [0:DEPTH-1];
  reg  [PTR_W-1:0]  wptr_q;
  reg  [PTR_W-1:0]  rptr_q;
  reg  [PTR_W:0]    cnt_q;
  reg               full_q;
  reg  [2:0]        ist_q;
  reg  [2:0]        imask_q;
  reg  [ADDR_W-1:0] awaddr_q;
  reg  [7:0]        wbyte_q;
  reg               wlane_q;
  reg               aw_have_q;
  reg               w_have_q;

  // ---------------------------------------------------------------
  // comparators
  // ---------------------------------------------------------------
  // halt-debug activity hides the bus from the comparators entirely
  wire       halt_busy = halt_debug_enable & halt_debug_active;
  wire       mon_en = mon_valid & ~halt_debug_hw_access & ~halt_busy; // RULE_01
  wire [2:0] hit;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_cmp
      wire [7:0] c      = cctl_q[g];
      wire       a_ok   = mon_addr == caddr_q[g]; // RULE_17
      wire       rw_ok  = ~c[`DTR_CC_RWE] | (c[`DTR_CC_RW] == mon_read);
      wire       sz_ok  = (g == 2) | ~c[`DTR_CC_SZE] | (c[`DTR_CC_SZ] == ~mon_word); // RULE_11
      wire       d_ok   = (g != 0) | c[`DTR_CC_NDB] | (((mon_data ^ cdata_q) & cmask_q) == 16'h0000);
      wire       tag_ok = ~c[`DTR_CC_TAG] | tag_exec;
      assign hit[g] = mon_en & c[`DTR_CC_COMPE] & a_ok & rw_ok & sz_ok & d_ok & tag_ok;
    end
  endgenerate

  // ---------------------------------------------------------------
  // bus slave decode
  // ---------------------------------------------------------------
  wire [5:0] widx  = awaddr_q[7:2];
  wire [5:0] ridx  = s_axi_araddr[7:2];
  wire       wr_go = aw_have_q & w_have_q & ~s_axi_bvalid;
  wire       rd_go = s_axi_arvalid & s_axi_arready;
  wire       bank_ok = bank_q != `DTR_BANK_NONE;
  wire [1:0] bsel    = bank_q;
  wire       trace_ok = tctl_q[`DTR_TCTL_TSOURCE] & ~chip_secure; // RULE_03
  wire       wr_c1   = wr_go & wlane_q & (widx == `DTR_IDX_CTL1);
  wire       immediate_trigger_wr = wr_c1 & wbyte_q[`DTR_C1_IMMEDIATE_TRIGGER]; // RULE_07
  wire       arm_set = wr_c1 & wbyte_q[`DTR_C1_ARM] & ~arm_q;
  // protected writes see the arm bit as it stood before this write
  wire       free_wr = wr_go & wlane_q & ~arm_q; // RULE_05

  function mapped;
    input [5:0] i;
    begin
      mapped = (i >= `DTR_IDX_CTL1) && (i <= `DTR_IDX_IRQ_MASK);
    end
  endfunction

  reg [7:0] rbyte;
  always @* begin
    rbyte = `DTR_ZERO8;
    case (ridx)
      `DTR_IDX_CTL1:     rbyte = {arm_q, 1'b0, 1'b0, hms_q, bre_q, 1'b0, bank_q}; // RULE_06 RULE_07
      `DTR_IDX_STATUS: begin
        rbyte[7] = full_q; // RULE_12
        case (state_q)
          ST_S1:    rbyte[2:0] = `DTR_SSF_S1;
          ST_S2:    rbyte[2:0] = `DTR_SSF_S2;
          ST_S3:    rbyte[2:0] = `DTR_SSF_S3;
          ST_FINAL: rbyte[2:0] = `DTR_SSF_FINAL;
          default:  rbyte[2:0] = `DTR_SSF_IDLE;
        endcase
      end
      `DTR_IDX_TCTL:     rbyte = tctl_q;
      `DTR_IDX_CTL2:     rbyte = ctl2_q;
      `DTR_IDX_TBH:      rbyte = tbuf[rptr_q][15:8]; // RULE_17
      `DTR_IDX_TBL:      rbyte = tbuf[rptr_q][7:0];
      `DTR_IDX_CNT:      rbyte = {full_q, 1'b0, {(6-PTR_W-1){1'b0}}, cnt_q}; // RULE_12
      `DTR_IDX_SCR:      rbyte = bank_ok ? {4'h0, scr_q[bsel]} : {5'h00, mflag_q}; // RULE_14
      `DTR_IDX_CCTL: begin
        case (bank_q) // RULE_10 RULE_11
          `DTR_BANK_A: rbyte = cctl_q[0] & `DTR_CCA_MASK;
          `DTR_BANK_B: rbyte = cctl_q[1] & `DTR_CCB_MASK;
          `DTR_BANK_C: rbyte = cctl_q[2] & `DTR_CCC_MASK;
          default:     rbyte = `DTR_ZERO8;
        endcase
      end
      `DTR_IDX_AH:       rbyte = bank_ok ? {6'h00, caddr_q[bsel][17:16]} : `DTR_ZERO8;
      `DTR_IDX_AM:       rbyte = bank_ok ? caddr_q[bsel][15:8] : `DTR_ZERO8;
      `DTR_IDX_AL:       rbyte = bank_ok ? caddr_q[bsel][7:0] : `DTR_ZERO8;
      // data compare bytes belong to bank A only
      `DTR_IDX_DH:       rbyte = (bank_q == `DTR_BANK_A) ? cdata_q[15:8] : `DTR_ZERO8;
      `DTR_IDX_DL:       rbyte = (bank_q == `DTR_BANK_A) ? cdata_q[7:0] : `DTR_ZERO8;
      `DTR_IDX_DMH:      rbyte = (bank_q == `DTR_BANK_A) ? cmask_q[15:8] : `DTR_ZERO8;
      `DTR_IDX_DML:      rbyte = (bank_q == `DTR_BANK_A) ? cmask_q[7:0] : `DTR_ZERO8;
      `DTR_IDX_IRQ_STAT: rbyte = {5'h00, ist_q};
      `DTR_IDX_IRQ_MASK: rbyte = {5'h00, imask_q};
      default:           rbyte = `DTR_ZERO8;
    endcase
  end

  // ---------------------------------------------------------------
  // sequencer and trace events
  // ---------------------------------------------------------------
  reg  [4:0] state_d;
  reg        seq_match;
  always @* begin
    state_d   = state_q;
    seq_match = 1'b0;
    case (state_q)
      ST_S1: if (hit[0]) begin
        seq_match = 1'b1;
        state_d   = scr_q[0][0] ? ST_S2 : ST_FINAL;
      end
      ST_S2: if (hit[1]) begin
        seq_match = 1'b1;
        state_d   = scr_q[1][0] ? ST_S3 : ST_FINAL;
      end
      ST_S3: if (hit[2]) begin
        seq_match = 1'b1;
        state_d   = ST_FINAL;
      end
      ST_IDLE:  state_d = ST_IDLE;
      ST_FINAL: state_d = ST_FINAL;
      default:  state_d = ST_IDLE;
    endcase
    // trigger ignored once a trace is already running
    if (immediate_trigger_wr && (arm_q || arm_set) && !tracing_q && state_q != ST_FINAL)
      state_d = ST_FINAL;
  end

  wire enter_final = state_d == ST_FINAL && state_q != ST_FINAL;
  wire trace_wr    = tracing_q & mon_en & trace_ok & ~full_q; // RULE_03
  wire trace_done  = tracing_q & (full_q | ~trace_ok);
  // breakpoint fires at once without trace, or on trace completion; held off while halted
  wire brk_now     = ((state_q == ST_FINAL) & ~tracing_q & arm_q | trace_done) & ~halt_busy; // RULE_01 RULE_16
  wire to_halt     = hms_q & halt_debug_enable; // RULE_04

  // ---------------------------------------------------------------
  // state update
  // ---------------------------------------------------------------
  integer k;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `DTR_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `DTR_RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      awaddr_q      <= {ADDR_W{1'b0}};
      wbyte_q       <= `DTR_ZERO8;
      wlane_q       <= 1'b0;
      arm_q         <= 1'b0;
      hms_q         <= 1'b0;
      bre_q         <= 1'b0;
      bank_q        <= `DTR_BANK_A;
      tctl_q        <= `DTR_ZERO8;
      ctl2_q        <= `DTR_ZERO8;
      cdata_q       <= 16'h0000;
      cmask_q       <= 16'h0000;
      mflag_q       <= 3'h0;
      state_q       <= ST_IDLE;
      tracing_q     <= 1'b0;
      wptr_q        <= {PTR_W{1'b0}};
      rptr_q        <= {PTR_W{1'b0}};
      cnt_q         <= {(PTR_W+1){1'b0}};
      full_q        <= 1'b0;
      ist_q         <= 3'h0;
      imask_q       <= 3'h0;
      brk_halt_q    <= 1'b0;
      brk_swi_q     <= 1'b0;
      irq_q         <= 1'b0;
      for (k = 0; k < 3; k = k + 1) begin
        cctl_q[k]  <= `DTR_ZERO8;
        caddr_q[k] <= 18'h00000;
        scr_q[k]   <= 4'h0;
      end
    end else begin
      // write channel: address and data taken in either order
      s_axi_awready <= ~aw_have_q & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready  <= ~w_have_q & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wbyte_q  <= s_axi_wdata[7:0];
        wlane_q  <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(widx) ? `DTR_RESP_OKAY : `DTR_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // read channel: one read at a time, answer one cycle after acceptance
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rbyte};
        s_axi_rresp  <= mapped(ridx) ? `DTR_RESP_OKAY : `DTR_RESP_SLVERR;
        // low byte read completes the word and steps to the next entry
        if (ridx == `DTR_IDX_TBL)
          rptr_q <= rptr_q + 1'b1; // RULE_17
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end

      // control one: arm and bank select always, 4:3 only while unarmed
      if (wr_c1) begin
        arm_q  <= wbyte_q[`DTR_C1_ARM]; // RULE_06
        bank_q <= wbyte_q[1:0]; // RULE_06
        if (!arm_q) begin // RULE_08 RULE_09
          hms_q <= wbyte_q[`DTR_C1_HMS];
          bre_q <= wbyte_q[`DTR_C1_BRE];
        end
      end
      if (free_wr) begin
        case (widx)
          `DTR_IDX_TCTL: tctl_q <= wbyte_q & `DTR_TCTL_MASK;
          `DTR_IDX_CTL2: ctl2_q <= wbyte_q & `DTR_CTL2_MASK;
          `DTR_IDX_SCR:  if (bank_ok) scr_q[bsel] <= wbyte_q[3:0]; // RULE_14
          `DTR_IDX_CCTL: begin
            case (bank_q) // RULE_10 RULE_11
              `DTR_BANK_A: cctl_q[0] <= wbyte_q & `DTR_CCA_MASK;
              `DTR_BANK_B: cctl_q[1] <= wbyte_q & `DTR_CCB_MASK;
              `DTR_BANK_C: cctl_q[2] <= wbyte_q & `DTR_CCC_MASK;
              default:     cctl_q[0] <= cctl_q[0];
            endcase
          end
          `DTR_IDX_AH:  if (bank_ok) caddr_q[bsel][17:16] <= wbyte_q[1:0]; // RULE_17
          `DTR_IDX_AM:  if (bank_ok) caddr_q[bsel][15:8] <= wbyte_q;
          `DTR_IDX_AL:  if (bank_ok) caddr_q[bsel][7:0] <= wbyte_q;
          `DTR_IDX_DH:  if (bank_q == `DTR_BANK_A) cdata_q[15:8] <= wbyte_q;
          `DTR_IDX_DL:  if (bank_q == `DTR_BANK_A) cdata_q[7:0] <= wbyte_q;
          `DTR_IDX_DMH: if (bank_q == `DTR_BANK_A) cmask_q[15:8] <= wbyte_q;
          `DTR_IDX_DML: if (bank_q == `DTR_BANK_A) cmask_q[7:0] <= wbyte_q;
          default:      tctl_q <= tctl_q;
        endcase
      end
      if (wr_go && wlane_q && widx == `DTR_IDX_IRQ_MASK)
        imask_q <= wbyte_q[2:0];

      // sequencer; halt entry leaves arm alone, only completion or a write clearing arm clears it
      brk_halt_q <= 1'b0;
      brk_swi_q  <= 1'b0;
      if (arm_set) begin
        state_q   <= ST_S1; // RULE_15
        tracing_q <= 1'b0;
        mflag_q   <= 3'h0;
        wptr_q    <= {PTR_W{1'b0}};
        rptr_q    <= {PTR_W{1'b0}};
        cnt_q     <= {(PTR_W+1){1'b0}};
        full_q    <= 1'b0;
        if (immediate_trigger_wr)
          state_q <= ST_FINAL;
      end else if (wr_c1 && !wbyte_q[`DTR_C1_ARM]) begin
        state_q   <= ST_IDLE;
        tracing_q <= 1'b0;
      end else if (arm_q) begin // RULE_02
        state_q <= state_d;
        if (seq_match)
          mflag_q <= mflag_q | hit;
        if (enter_final)
          tracing_q <= trace_ok; // RULE_03
        if (trace_wr) begin
          tbuf[wptr_q] <= mon_addr[15:0];
          wptr_q       <= wptr_q + 1'b1;
          cnt_q        <= cnt_q + 1'b1;
          if (cnt_q == DEPTH - 1)
            full_q <= 1'b1;
        end
        if (brk_now) begin
          brk_halt_q <= bre_q & to_halt; // RULE_04 RULE_16
          brk_swi_q  <= bre_q & ~to_halt;
          arm_q      <= 1'b0;
          tracing_q  <= 1'b0;
          state_q    <= ST_IDLE;
        end
      end

      // sticky events; a new event wins over a same-cycle clear
      for (k = 0; k < 3; k = k + 1) begin
        if (wr_go && wlane_q && widx == `DTR_IDX_IRQ_STAT && wbyte_q[k])
          ist_q[k] <= 1'b0;
      end
      if (arm_q && brk_now && bre_q)
        ist_q[`DTR_IRQ_BP] <= 1'b1;
      if (arm_q && seq_match)
        ist_q[`DTR_IRQ_MATCH] <= 1'b1;
      if (arm_q && trace_wr && cnt_q == DEPTH - 1)
        ist_q[`DTR_IRQ_FULL] <= 1'b1;
      irq_q <= |(ist_q & imask_q);
    end
  end

endmodule

// File: dtr_debug_trigger_sva.sv
// assertion checker for the debug trigger register port
`timescale 1ns/1ps
module dtr_debug_trigger_sva #(
  parameter ADDR_W = 8
) (
  input wire              aclk,
  input wire              aresetn,
  input wire              s_axi_awvalid,
  input wire              s_axi_awready,
  input wire              s_axi_wvalid,
  input wire              s_axi_wready,
  input wire              s_axi_bvalid,
  input wire              s_axi_bready,
  input wire [1:0]        s_axi_bresp,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire              s_axi_arvalid,
  input wire              s_axi_arready,
  input wire [31:0]       s_axi_rdata,
  input wire [1:0]        s_axi_rresp,
  input wire              s_axi_rvalid,
  input wire              s_axi_rready,
  input wire              halt_debug_enable,
  input wire              halt_debug_active,
  input wire              brk_halt_q,
  input wire              brk_swi_q
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  wr_answer_a: assert property (wr_both |-> ##2 s_axi_bvalid) else $error("write response late");
  rd_answer_a: assert property (rd_take |=> s_axi_rvalid) else $error("read response late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped");
  busy_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while busy");
  unmapped_err_a: assert property (rd_take ##0 (s_axi_araddr[7:2] < 6'h20 || s_axi_araddr[7:2] > 6'h31)
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h00000000) else $error("unmapped read not refused");
  immediate_trigger_zero_a: assert property (rd_take ##0 s_axi_araddr == 8'h80 |=> s_axi_rdata[6] == 1'b0)
    else $error("trigger bit read as one");
  halt_quiet_a: assert property ((halt_debug_enable && halt_debug_active)[*3] |-> !brk_halt_q && !brk_swi_q)
    else $error("breakpoint while halted");
  halt_enable_a: assert property (brk_halt_q |-> $past(halt_debug_enable))
    else $error("halt breakpoint without enable");
  brk_pulse_a: assert property (brk_halt_q || brk_swi_q |=> !brk_halt_q && !brk_swi_q)
    else $error("breakpoint pulse too long");
  brk_single_a: assert property (!(brk_halt_q && brk_swi_q))
    else $error("both breakpoint kinds at once");
endmodule
bind dtr_debug_trigger dtr_debug_trigger_sva #(.ADDR_W(ADDR_W)) u_sva (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .halt_debug_enable, .halt_debug_active,
  .brk_halt_q, .brk_swi_q);

// File: dtr_debug_trigger_tb.sv
// self-checking testbench of the debug trigger register interface
`timescale 1ns/1ps
module dtr_debug_trigger_tb;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, rv;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  resp;
  logic        bh, bs;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         brk_halt_q, brk_swi_q, irq_q;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         mon_valid, mon_read, mon_word, tag_exec;
  wire         halt_debug_enable, halt_debug_active, halt_debug_hw_access, chip_secure;
  wire  [17:0] mon_addr;
  wire  [15:0] mon_data;
  integer      errors = 0, cmp_count = 0;
  logic [7:0]  cmask [3] = '{8'hFF, 8'hFD, 8'h3D};
  logic [3:0]  md [5] = '{4'b0000, 4'b1000, 4'b1100, 4'b0010, 4'b0001};
  logic [9:0]  ex [5] = '{10'h118, 10'h218, 10'h098, 10'h098, 10'h118};
  dtr_debug_trigger dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .mon_valid, .mon_addr, .mon_data, .mon_read, .mon_word, .tag_exec,
    .halt_debug_enable, .halt_debug_active, .halt_debug_hw_access, .chip_secure,
    .brk_halt_q, .brk_swi_q, .irq_q);
  dtr_cpu_model cpu (.aclk, .mon_valid, .mon_addr, .mon_data, .mon_read, .mon_word, .tag_exec,
    .halt_debug_enable, .halt_debug_active, .halt_debug_hw_access, .chip_secure);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // ----------
  // report, check, bus and breakpoint tasks
  // ----------
  task summarize;
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // response ready rises at the second clock, no later than the response, so the slave never has to hold its answer
  task wr(input logic [7:0] a, input logic [7:0] d);
    integer n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (n == 2) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task rd(input logic [7:0] a);
    integer n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (n == 2) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    rv = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task rchk(input string what, input logic [7:0] a, input logic [7:0] e);
    rd(a);
    check(what, rv, {24'h000000, e});
  endtask
  task wbrk;
    bh = 1'b0;
    bs = 1'b0;
    repeat (20) begin
      @(posedge aclk);
      bh = bh | brk_halt_q;
      bs = bs | brk_swi_q;
    end
  endtask
  task irqchk(input logic e);
    repeat (2) @(posedge aclk);
    check("interrupt", irq_q, e);
  endtask
  initial begin
    #200000;
    errors++;
    summarize;
  end
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk("control one", 8'h80, 8'h00);
    wr(8'h80, 8'h5B);
    rchk("control one", 8'h80, 8'h1B);
    wr(8'h9C, 8'hFF);
    rchk("match flags", 8'h9C, 8'h00);
    rchk("empty window", 8'hA0, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(8'h80, i[7:0]);
      wr(8'hA0, 8'hFF);
      wr(8'h9C, 8'hFF);
      rchk("comparator control", 8'hA0, cmask[i]);
      rchk("state control", 8'h9C, 8'h0F);
    end
    wr(8'hA4, 8'hFF);
    rchk("address upper", 8'hA4, 8'h03);
    wr(8'h80, 8'h00);
    wr(8'h9C, 8'h00);
    wr(8'hA0, 8'h03);
    wr(8'hA4, 8'h01);
    wr(8'hA8, 8'h23);
    wr(8'hAC, 8'h45);
    for (int m = 0; m < 5; m++) begin
      cpu.mode(md[m][3], md[m][2], md[m][1], md[m][0]);
      wr(8'h88, (m == 4) ? 8'h40 : 8'h00);
      wr(8'h80, 8'h98);
      rchk("sequencer state", 8'h84, 8'h01);
      cpu.cycle(18'h12345);
      wbrk;
      check("halt break", bh, ex[m][9]);
      check("trap break", bs, ex[m][8]);
      rchk("arm after hit", 8'h80, ex[m][7:0]);
      wr(8'h80, 8'h00);
    end
    rchk("trace count", 8'h98, 8'h00);
    rd(8'h84);
    check("status full", rv[7], 1'b0);
    cpu.mode(1'b0, 1'b0, 1'b0, 1'b0);
    wr(8'h80, 8'h80);
    wr(8'h88, 8'h4D);
    rchk("trace control", 8'h88, 8'h40);
    wr(8'h80, 8'h99);
    rchk("control one", 8'h80, 8'h81);
    wr(8'h80, 8'h18);
    rchk("control one", 8'h80, 8'h00);
    wr(8'h80, 8'h18);
    rchk("control one", 8'h80, 8'h18);
    wr(8'h88, 8'h00);
    wr(8'h80, 8'h88);
    cpu.cycle(18'h12345);
    wbrk;
    irqchk(1'b0);
    wr(8'hC4, 8'h01);
    irqchk(1'b1);
    wr(8'hC4, 8'h00);
    irqchk(1'b0);
    wr(8'hC4, 8'h01);
    wr(8'hC0, 8'h07);
    irqchk(1'b0);
    wr(8'h88, 8'h40);
    wr(8'h80, 8'h88);
    cpu.cycle(18'h12345);
    wbrk;
    check("break during trace", bs, 1'b0);
    repeat (8) cpu.cycle(18'h12345);
    wbrk;
    check("break after trace", bs, 1'b1);
    rchk("trace count", 8'h98, 8'h88);
    rchk("status full", 8'h84, 8'h80);
    rchk("trace high", 8'h90, 8'h23);
    rchk("trace low", 8'h94, 8'h45);
    rd(8'hFC);
    check("unmapped response", resp, 2'h2);
    summarize;
  end
endmodule

// File: dtr_regs.vh
// register map, field positions and reset values of the debug trigger register interface
`ifndef DTR_REGS_VH
`define DTR_REGS_VH

// register indices; byte address is four times the index
`define DTR_IDX_CTL1      6'h20
`define DTR_IDX_STATUS    6'h21
`define DTR_IDX_TCTL      6'h22
`define DTR_IDX_CTL2      6'h23
`define DTR_IDX_TBH       6'h24
`define DTR_IDX_TBL       6'h25
`define DTR_IDX_CNT       6'h26
`define DTR_IDX_SCR       6'h27
`define DTR_IDX_CCTL      6'h28
`define DTR_IDX_AH        6'h29
`define DTR_IDX_AM        6'h2A
`define DTR_IDX_AL        6'h2B
`define DTR_IDX_DH        6'h2C
`define DTR_IDX_DL        6'h2D
`define DTR_IDX_DMH       6'h2E
`define DTR_IDX_DML       6'h2F
`define DTR_IDX_IRQ_STAT  6'h30
`define DTR_IDX_IRQ_MASK  6'h31

// control register one fields
`define DTR_C1_ARM        7
`define DTR_C1_IMMEDIATE_TRIGGER       6
`define DTR_C1_HMS        4
`define DTR_C1_BRE        3

// bank select codes
`define DTR_BANK_A        2'h0
`define DTR_BANK_B        2'h1
`define DTR_BANK_C        2'h2
`define DTR_BANK_NONE     2'h3

// comparator control fields
`define DTR_CC_SZE        7
`define DTR_CC_SZ         6
`define DTR_CC_TAG        5
`define DTR_CC_RW         3
`define DTR_CC_RWE        2
`define DTR_CC_NDB        1
`define DTR_CC_COMPE      0

// writable masks and readable masks
`define DTR_TCTL_MASK     8'h4D
`define DTR_TCTL_TSOURCE  6
`define DTR_CTL2_MASK     8'h03
`define DTR_CCA_MASK      8'hFF
`define DTR_CCB_MASK      8'hFD
`define DTR_CCC_MASK      8'h3D
`define DTR_AH_MASK       8'h03
`define DTR_SCR_MASK      8'h0F

// status codes of the sequencer
`define DTR_SSF_IDLE      3'h0
`define DTR_SSF_S1        3'h1
`define DTR_SSF_S2        3'h2
`define DTR_SSF_S3        3'h3
`define DTR_SSF_FINAL     3'h4

// interrupt status bits
`define DTR_IRQ_BP        0
`define DTR_IRQ_MATCH     1
`define DTR_IRQ_FULL      2

// bus responses and reset values
`define DTR_RESP_OKAY     2'h0
`define DTR_RESP_SLVERR   2'h2
`define DTR_ZERO8         8'h00

`endif
